// ---- hdl/hbm_lane_mapper.sv ----
// module: host byte-lane mapper for the parallel register port
// How it works
// - no strap resistors fitted selects the isa-like personality
// - pull-up on eeprom clock strap alone selects the 186-like personality
// - isa-like: even read gives pair, odd read both lanes, writes low lane
// - 186-like: read gives even low, odd high; write lane follows offset parity
// - reading offset 1fh pulses device_reset; the mapper itself keeps its mode and still serves the host
`timescale 1ns/1ns
module hbm_lane_mapper
#(
  parameter int ADDR_W = hbm_pkg::ADDR_W
)
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // strap pins, sampled after reset
  input  wire logic              eeprom_select_strap,
  input  wire logic              eeprom_clock_strap,
  // host port
  input  wire logic [ADDR_W-1:0] host_addr,
  input  wire logic              host_rd,
  input  wire logic              host_wr,
  input  wire logic [15:0]       system_data_lanes_in,
  output logic      [15:0]       system_data_lanes_out,
  output logic      [1:0]        system_data_lanes_oe,
  // register file side
  output logic      [4:0]        reg_rd_ofs_lo,
  output logic      [4:0]        reg_rd_ofs_hi,
  input  wire logic [7:0]        reg_rd_data_lo,
  input  wire logic [7:0]        reg_rd_data_hi,
  output logic                   reg_wr,
  output logic      [4:0]        reg_wr_ofs,
  output logic      [7:0]        reg_wr_data,
  // packet data port side
  output logic                   packet_data_port_rd,
  output logic                   packet_data_port_wr,
  output logic      [15:0]       packet_data_port_wdata,
  input  wire logic [15:0]       packet_data_port_rdata,
  // status
  output logic                   mode_186,
  output logic                   device_reset
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic                 strap_taken;
    logic [2:0]           settle;
    hbm_pkg::hbm_mode_e   mode;
    logic                 rd_dly;
    logic                 wr_dly;
    logic [15:0]          dout;
    logic [1:0]           oe;
    logic                 wr_pulse;
    logic [4:0]           wr_ofs;
    logic [7:0]           wr_data;
    logic                 dp_rd;
    logic                 dp_wr;
    logic [15:0]          dp_wdata;
    logic [3:0]           rst_cnt;
  } hbm_state_s;

  hbm_state_s st_reg;
  hbm_state_s st_next;

  logic       sel_lvl;
  logic       ck_lvl;
  logic [4:0] ofs;
  logic [4:0] even_ofs;
  logic [4:0] odd_ofs;
  logic       rd_start;

  // ---------------------------------------------------------------
  // strap synchronisers
  // ---------------------------------------------------------------
  // straps are free pins, so each passes four flip-flops before use
  hbm_sync3 #(.RESET_VAL(1'b0)) u_sync_sel
  (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .pin_in    (eeprom_select_strap),
    .level_out (sel_lvl)
  );

  hbm_sync3 #(.RESET_VAL(1'b0)) u_sync_ck
  (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .pin_in    (eeprom_clock_strap),
    .level_out (ck_lvl)
  );

  // strap decode, used only where the straps are latched into the mode
  function automatic hbm_pkg::hbm_mode_e decode_strap(input logic sel, input logic ck);
    if (!sel && ck)
      decode_strap = hbm_pkg::HBM_MODE_186;
    else if (!sel && !ck)
      decode_strap = hbm_pkg::HBM_MODE_ISA;
    else
      decode_strap = hbm_pkg::HBM_MODE_RSV;
  endfunction

  // ---------------------------------------------------------------
  // address split
  // ---------------------------------------------------------------
  // bit 5 reaches beyond the map and is ignored here
  assign ofs      = host_addr[4:0];
  assign even_ofs = {ofs[4:1], 1'b0};
  assign odd_ofs  = {ofs[4:1], 1'b1};
  assign rd_start = host_rd && !st_reg.rd_dly;

  // read address steering to the register file
  always_comb
  begin
    reg_rd_ofs_lo = ofs;
    reg_rd_ofs_hi = odd_ofs;
    if (st_reg.mode == hbm_pkg::HBM_MODE_186)
      reg_rd_ofs_lo = even_ofs;
    else if (ofs[0])
      reg_rd_ofs_hi = ofs;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_next          = st_reg;
    st_next.rd_dly   = host_rd;
    // edge detect on the write strobe, so a long strobe writes once
    st_next.wr_dly   = host_wr;
    st_next.wr_pulse = 1'b0;
    st_next.dp_rd    = 1'b0;
    st_next.dp_wr    = 1'b0;
    // straps latched once, after the synchronisers have settled;
    // the synchronisers restart from their reset value, so their
    // level is only valid after a few enabled edges
    if (!st_reg.strap_taken)
    begin
      if (st_reg.settle == hbm_pkg::STRAP_SETTLE_CYCLES)
      begin
        st_next.strap_taken = 1'b1;
        st_next.mode        = decode_strap(sel_lvl, ck_lvl);
      end
      else
        st_next.settle = st_reg.settle + 3'h1;
    end
    // soft reset pulse runs down; host cycles are still served
    if (st_reg.rst_cnt != 4'h0)
      st_next.rst_cnt = st_reg.rst_cnt - 4'h1;
    // read data: lanes driven one edge behind the strobe, from each edge that samples it high
    st_next.oe = host_rd ? 2'b11 : 2'b00;
    if (host_rd)
    begin
      if (ofs == hbm_pkg::OFS_DATA_PORT)
      begin
        st_next.dout = packet_data_port_rdata;
        st_next.dp_rd = rd_start;
      end
      else if (ofs == hbm_pkg::OFS_UNUSED)
        st_next.dout = 16'h0000;
      else if (ofs == hbm_pkg::OFS_NO_HIGH)
      begin
        st_next.dout = {8'h00, reg_rd_data_lo};
        st_next.oe   = 2'b01;
      end
      else
        st_next.dout = {reg_rd_data_hi, reg_rd_data_lo};
      if (rd_start && ofs == hbm_pkg::OFS_SOFT_RESET)
        st_next.rst_cnt = hbm_pkg::SOFT_RST_CYCLES;
    end
    // writes, taken on the first cycle of the strobe only
    if (host_wr && !st_reg.wr_dly)
    begin
      if (ofs == hbm_pkg::OFS_DATA_PORT)
      begin
        st_next.dp_wr    = 1'b1;
        st_next.dp_wdata = system_data_lanes_in;
      end
      else if (ofs != hbm_pkg::OFS_UNUSED)
      begin
        st_next.wr_pulse = 1'b1;
        st_next.wr_ofs   = ofs;
        if (st_reg.mode == hbm_pkg::HBM_MODE_186 && ofs[0])
          st_next.wr_data = system_data_lanes_in[15:8];
        else
          st_next.wr_data = system_data_lanes_in[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // state register; a soft reset does not clear the latched mode
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      st_reg <= '{1'b0, 3'h0, hbm_pkg::HBM_MODE_ISA, 1'b0, 1'b0,
                  16'h0000, 2'b00, 1'b0, 5'h00, hbm_pkg::LANE_RESET,
                  1'b0, 1'b0, 16'h0000, 4'h0};
    else if (clk_en)
      st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // lane enables leave the same register stage as the data, so both turn on one edge
  assign system_data_lanes_out  = st_reg.dout;
  assign system_data_lanes_oe   = st_reg.oe;
  assign reg_wr                 = st_reg.wr_pulse;
  assign reg_wr_ofs             = st_reg.wr_ofs;
  assign reg_wr_data            = st_reg.wr_data;
  assign packet_data_port_rd    = st_reg.dp_rd;
  assign packet_data_port_wr    = st_reg.dp_wr;
  assign packet_data_port_wdata = st_reg.dp_wdata;
  assign mode_186               = (st_reg.mode == hbm_pkg::HBM_MODE_186);
  assign device_reset           = (st_reg.rst_cnt != 4'h0);
endmodule

// ---- hdl/hbm_pkg.sv ----
// package: offsets, strap codes and timing constants for the host byte-lane mapper
package hbm_pkg;
  // register offsets on the host port
  localparam logic [4:0] OFS_DATA_PORT  = 5'h10;
  localparam logic [4:0] OFS_UNUSED     = 5'h11;
  localparam logic [4:0] OFS_NO_HIGH    = 5'h1e;
  localparam logic [4:0] OFS_SOFT_RESET = 5'h1f;
  // field widths
  localparam int         ADDR_W         = 6;
  localparam int         OFS_W          = 5;
  localparam int         LANE_W         = 8;
  // values after reset
  localparam logic [7:0] LANE_RESET     = 8'h00;
  localparam logic [1:0] SYNC_RESET     = 2'b00;
  // soft reset pulse length in cycles
  localparam logic [3:0] SOFT_RST_CYCLES = 4'h8;
  // enabled edges after reset before the strap synchronisers show the pin
  localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;

  // bus personality taken from the straps
  typedef enum logic [1:0]
  {
    HBM_MODE_ISA = 2'b00,
    HBM_MODE_186 = 2'b01,
    HBM_MODE_RSV = 2'b11
  } hbm_mode_e;
endpackage

// ---- hdl/hbm_sync3.sv ----
// module: three-stage synchroniser for one pin, change taken when stages two and three agree
`timescale 1ns/1ns
module hbm_sync3
#(
  parameter logic RESET_VAL = 1'b0
)
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  // pin and result
  input  wire logic pin_in,
  output logic      level_out
);

  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } hbm_sync_s;

  hbm_sync_s st_reg;
  hbm_sync_s st_next;

  // first stage feeds only the second stage
  always_comb
  begin
    st_next     = st_reg;
    st_next.s1  = pin_in;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    if (st_reg.s2 == st_reg.s3)
      st_next.lvl = st_reg.s3;
  end

  // state register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      st_reg <= '{RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    else if (clk_en)
      st_reg <= st_next;
  end

  assign level_out = st_reg.lvl;
endmodule

// ---- bench/hbm_lane_mapper_monitor.sv ----
// checker: port-level properties of the host byte-lane mapper
`timescale 1ns/1ns
module hbm_lane_mapper_monitor
#(
  parameter int ADDR_W = 6
)
(
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // host side
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic              host_rd,
  input wire logic              host_wr,
  input wire logic [15:0]       system_data_lanes_in,
  input wire logic [1:0]        system_data_lanes_oe,
  // decoded side
  input wire logic [4:0]        reg_rd_ofs_lo,
  input wire logic [4:0]        reg_rd_ofs_hi,
  input wire logic              reg_wr,
  input wire logic [7:0]        reg_wr_data,
  input wire logic              packet_data_port_wr,
  input wire logic              device_reset,
  input wire logic              mode_186
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // bit 5 is ignored, so every rule looks at the low five bits
  logic [4:0] ofs;
  logic       plain;
  assign ofs = host_addr[4:0];
  assign plain = ofs < 5'h1e && ofs[4:1] != 4'h8;
  property p_isa_rd;
    host_rd && !mode_186 && plain |-> reg_rd_ofs_lo == ofs && reg_rd_ofs_hi == (ofs | 5'h01);
  endproperty
  a_isa_rd: assert property (p_isa_rd) else $error("isa read lanes wrong");
  property p_186_rd;
    host_rd && mode_186 && plain |-> reg_rd_ofs_lo == {ofs[4:1], 1'b0} && reg_rd_ofs_hi == {ofs[4:1], 1'b1};
  endproperty
  a_186_rd: assert property (p_186_rd) else $error("186 read lanes wrong");
  property p_isa_wr;
    $rose(host_wr) && !mode_186 && ofs[4:1] != 4'h8 |=> reg_wr && reg_wr_data == $past(system_data_lanes_in[7:0]);
  endproperty
  a_isa_wr: assert property (p_isa_wr) else $error("isa write lane wrong");
  property p_186_wr;
    $rose(host_wr) && mode_186 && ofs[4:1] != 4'h8 |=> reg_wr
      && reg_wr_data == ($past(ofs[0]) ? $past(system_data_lanes_in[15:8]) : $past(system_data_lanes_in[7:0]));
  endproperty
  a_186_wr: assert property (p_186_wr) else $error("186 write lane wrong");
  property p_unused_wr;
    $rose(host_wr) && ofs == 5'h11 |=> (!reg_wr && !packet_data_port_wr) [*2];
  endproperty
  a_unused_wr: assert property (p_unused_wr) else $error("write to unused offset acted");
  property p_dp_wr;
    $rose(host_wr) && ofs == 5'h10 |=> packet_data_port_wr && !reg_wr;
  endproperty
  a_dp_wr: assert property (p_dp_wr) else $error("data port write missed");
  property p_no_high;
    host_rd && ofs == 5'h1e |=> system_data_lanes_oe == 2'b01;
  endproperty
  a_no_high: assert property (p_no_high) else $error("high lane driven at 1e");
  property p_soft_rst;
    host_rd && ofs == 5'h1f |=> device_reset [*8] ##1 $stable(mode_186);
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset pulse wrong");
endmodule

// ---- bench/hbm_regfile_model.sv ----
// model: register file and data port behind the mapper
`timescale 1ns/1ns
module hbm_regfile_model
(
  // read offsets
  input  wire logic [4:0]  reg_rd_ofs_lo,
  input  wire logic [4:0]  reg_rd_ofs_hi,
  // read data
  output logic      [7:0]  reg_rd_data_lo,
  output logic      [7:0]  reg_rd_data_hi,
  output logic      [15:0] packet_data_port_rdata
);
  // contents echo the offset so a misrouted lane shows at once
  assign reg_rd_data_lo = {3'h5, reg_rd_ofs_lo};
  assign reg_rd_data_hi = {3'h5, reg_rd_ofs_hi};
  assign packet_data_port_rdata = 16'hc33c;
endmodule

// ---- bench/test_hbm_lane_mapper.sv ----
// testbench: both strap personalities exercised, reads over every offset, writes over all offsets but 1fh
`timescale 1ns/1ns
module test_hbm_lane_mapper;
  logic        sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, host_rd = 1'b0, host_wr = 1'b0;
  logic        eeprom_select_strap = 1'b0, eeprom_clock_strap = 1'b0;
  logic [5:0]  host_addr = 6'h00;
  logic [15:0] system_data_lanes_in = 16'h0000, system_data_lanes_out, packet_data_port_wdata, packet_data_port_rdata;
  logic [1:0]  system_data_lanes_oe;
  logic [4:0]  reg_rd_ofs_lo, reg_rd_ofs_hi, reg_wr_ofs;
  logic [7:0]  reg_rd_data_lo, reg_rd_data_hi, reg_wr_data;
  logic        reg_wr, packet_data_port_rd, packet_data_port_wr, mode_186, device_reset, rd_now;
  int          failures = 0, checks = 0, seed = 6463, m, i;
  int          rst_seen = 0, dprd_seen = 0, exp_rst = 0;
  logic [21:0] rq[$], wq[$];
  // design and the register file behind it
  hbm_lane_mapper i_hbm_lane_mapper (.*);
  hbm_regfile_model i_hbm_regfile_model (.*);
  always #10 sys_clk = ~sys_clk;
  // -----------------------------------------
  // compare and closing report
  // -----------------------------------------
  task automatic compare(string what, logic [21:0] exp, logic [21:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // -----------------------------------------
  // host cycles: one strobe cycle, then one idle cycle
  // -----------------------------------------
  task automatic rd_op(logic [4:0] o);
    logic [4:0] e;
    e = m[0] ? {o[4:1], 1'b0} : o;
    if (o == 5'h10)
      rq.push_back({6'h03, 16'hc33c});
    else if (o == 5'h11)
      rq.push_back({6'h03, 16'h0000});
    else if (o == 5'h1e)
      rq.push_back({6'h01, 8'h00, 3'h5, o});
    else if (o != 5'h1f)
      rq.push_back({6'h03, 3'h5, o | 5'h01, 3'h5, e});
    @(negedge sys_clk);
    host_addr = {seed[3], o};
    host_rd = 1'b1;
    @(negedge sys_clk);
    host_rd = 1'b0;
  endtask
  task automatic wr_op(logic [4:0] o, logic [15:0] d);
    if (o == 5'h10)
      wq.push_back({1'b1, o, d});
    else if (o != 5'h11)
      wq.push_back({1'b0, o, 8'h00, (m[0] && o[0]) ? d[15:8] : d[7:0]});
    @(negedge sys_clk);
    host_addr = {seed[2], o};
    system_data_lanes_in = d;
    host_wr = 1'b1;
    @(negedge sys_clk);
    host_wr = 1'b0;
  endtask
  // results: the oldest note is taken as each one appears
  always @(posedge sys_clk)
  begin
    rd_now = host_rd;
    #1;
    if (rd_now && rq.size() != 0)
      compare("read", rq.pop_front(), {4'h0, system_data_lanes_oe, system_data_lanes_oe[1] ? system_data_lanes_out[15:8]
        : 8'h00, system_data_lanes_out[7:0]});
    if (reg_wr)
      compare("reg write", wq.pop_front(), {1'b0, reg_wr_ofs, 8'h00, reg_wr_data});
    if (packet_data_port_wr)
      compare("port write", wq.pop_front(), {1'b1, 5'h10, packet_data_port_wdata});
    if (device_reset)
      rst_seen++;
    if (packet_data_port_rd)
      dprd_seen++;
  end
  // main sequence: isa straps, 186 straps, then a reserved strap pair
  initial
  begin
    for (m = 0; m < 3; m++)
    begin
      eeprom_clock_strap = m[0];
      eeprom_select_strap = m[1];
      rst = 1'b1;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      repeat (5) @(negedge sys_clk);
      compare("mode", 22'(m == 1), {21'h0, mode_186});
      for (i = 0; i < 31; i++)
      begin
        wr_op(i[4:0], 16'($random(seed)));
        rd_op(i[4:0]);
      end
      rd_op(5'h1f);
      // last pass freezes the clock enable in mid-pulse, stretching it
      clk_en = !m[1];
      repeat (4) @(negedge sys_clk);
      clk_en = 1'b1;
      repeat (12) @(negedge sys_clk);
      exp_rst += int'(hbm_pkg::SOFT_RST_CYCLES) + (m[1] ? 4 : 0);
      compare("reset cycles", 22'(exp_rst), 22'(rst_seen));
      compare("port reads", 22'(m + 1), 22'(dprd_seen));
      compare("mode kept", 22'(m == 1), {21'h0, mode_186});
      $display("personality %0d done", m);
    end
    compare("notes left", 22'h0, 22'(rq.size() + wq.size()));
    end_sim;
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    end_sim;
  end
endmodule
bind hbm_lane_mapper hbm_lane_mapper_monitor #(.ADDR_W(ADDR_W)) i_hbm_lane_mapper_monitor (.*);
